// *** verilog/agl_pkg.sv ***
package agl_pkg;

   // ************************************************************
   // Data path sizes
   // ************************************************************
   localparam int DATA_W     = 16;
   localparam int ADDR_W     = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W     = DATA_W + 2;

   // ************************************************************
   // Jumper configuration register addresses
   // ************************************************************
   localparam logic [4:0] JUMPER_CFG1_ADDR = 5'h12;
   localparam logic [4:0] JUMPER_CFG2_ADDR = 5'h13;

   // ************************************************************
   // Packet buffer pointers
   // ************************************************************
   localparam logic [ADDR_W-1:0] TX_BASE  = 16'h0000;
   localparam logic [ADDR_W-1:0] RX_BASE  = 16'h4000;
   localparam logic [ADDR_W-1:0] STEP_W16 = 16'h0002;
   localparam logic [ADDR_W-1:0] STEP_W8  = 16'h0001;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   // ************************************************************
   // Buffer sequencer states, Gray along idle-write-read-done
   // ************************************************************
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WR   = 2'b01,
      ST_RD   = 2'b11,
      ST_DONE = 2'b10
   } agl_state_t;

endpackage

// *** verilog/agl_glue.sv ***
// Contract
// - Request DMA while receive data waits or transmit buffer has room.
// - Signal channel ready when cycle can complete; polarity follows strap.
// - Drive 16-bit cycle indication low during sixteen-bit I/O cycles.
// - Two active-low transceiver enables, upper and lower byte lane.
// - Direction low for reads (chip to system), high for writes.
// - Pulse first configuration strobe low to read jumper register 0x12.
// - Pulse second configuration strobe low to read jumper register 0x13.
// - EEPROM option: shift clock, serial data out, serial data in.
// - ID PROM option: same three pins drive latched address lines.
// - PROM select high for serial EEPROM, low for parallel ID PROM.
// - Remote reset output follows special packet flag when enabled.
// - Control output pin is the complement of the software bit.
// - Buffer data bus runs 8-bit or 16-bit per width bit.
// - Drive a sixteen-bit buffer address reaching 64 kbytes.
// - Two active-low buffer selects: upper byte and lower byte.
// - Write strobe low on buffer writes, read strobe on reads.
// - Internal clocking stops while the powerdown bit is set.
`timescale 1ns/1ps

module agl_fifo
#(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
)
(
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic             i_en,
   // Fill side
   input  wire logic             i_valid,
   input  wire logic [WIDTH-1:0] i_data,
   output logic                  o_ready,
   // Drain side
   output logic                  o_valid,
   output logic [WIDTH-1:0]      o_data,
   input  wire logic             i_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_q;
   logic [AW:0]      rp_q;
   wire              push = i_en && i_valid && o_ready;
   wire              pop  = i_en && i_ready && o_valid;

   assign o_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
   assign o_valid = wp_q != rp_q;
   assign o_data  = mem[rp_q[AW-1:0]];

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (push)
            wp_q <= wp_q + 1'b1;
         if (pop)
            rp_q <= rp_q + 1'b1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (push)
         mem[wp_q[AW-1:0]] <= i_data;
   end
endmodule

module agl_glue
   import agl_pkg::*;
(
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // Host bus cycle
   input  wire logic              i_dev_sel,
   input  wire logic [4:0]        i_sa_low,
   input  wire logic              i_ior_n,
   input  wire logic              i_iow_n,
   input  wire logic              i_aen,
   input  wire logic              i_dmack_n,
   input  wire logic              i_sbhe_n,
   input  wire logic              i_sys16,
   input  wire logic [DATA_W-1:0] i_sd,
   output logic [DATA_W-1:0]      o_sd,
   output logic                   o_sd_oe,
   // Host handshake and transceivers
   output logic                   o_dma_req,
   output logic                   o_host_channel_ready,
   output logic                   o_io16_n,
   output logic                   o_upper_lane_xcvr_enable_n,
   output logic                   o_lower_lane_xcvr_enable_n,
   output logic                   o_xcvr_dir,
   output logic                   o_jumper_cfg1_strobe_n,
   output logic                   o_jumper_cfg2_strobe_n,
   // Configuration and status bits
   input  wire logic              i_ready_polarity_strap,
   input  wire logic              i_rx_avail,
   input  wire logic              i_buffer_width_select,
   input  wire logic              i_powerdown_bit,
   input  wire logic              i_remote_reset_enable,
   input  wire logic              i_special_packet_seen,
   input  wire logic              i_sw_control_bit,
   output logic                   o_remote_reset_out,
   output logic                   o_sw_control_out,
   // PROM port
   input  wire logic              i_prom_is_eeprom,
   input  wire logic              i_ee_clock,
   input  wire logic              i_ee_sdout,
   input  wire logic [2:0]        i_id_addr,
   output logic                   o_prom_type_select,
   output logic                   o_prom_clock_or_addr0,
   output logic                   o_prom_sdout_or_addr1,
   input  wire logic              i_prom_sdin_or_addr2,
   output logic                   o_prom_sdin_or_addr2,
   output logic                   o_prom_sdin_or_addr2_oe,
   output logic                   o_ee_sdin,
   // Packet buffer SRAM
   output logic [ADDR_W-1:0]      o_buf_addr,
   input  wire logic [DATA_W-1:0] i_buf_data,
   output logic [DATA_W-1:0]      o_buf_data,
   output logic                   o_buf_data_oe,
   output logic                   o_buffer_upper_byte_select_n,
   output logic                   o_buffer_lower_byte_select_n,
   output logic                   o_buffer_write_strobe_n,
   output logic                   o_buffer_read_strobe_n
);

   // ************************************************************
   // Cycle decode
   // ************************************************************
   wire run      = !i_powerdown_bit;
   wire dma_cyc  = i_aen && !i_dmack_n;
   wire io_cyc   = !i_aen && i_dev_sel;
   wire hit      = dma_cyc || io_cyc;
   wire rd_act   = hit && !i_ior_n;
   wire wr_act   = hit && !i_iow_n;
   wire cfg1_rd  = io_cyc && !i_ior_n && (i_sa_low == JUMPER_CFG1_ADDR);
   wire cfg2_rd  = io_cyc && !i_ior_n && (i_sa_low == JUMPER_CFG2_ADDR);
   wire cfg_rd   = cfg1_rd || cfg2_rd;
   wire buf_rd   = rd_act && !cfg_rd;
   wire wide     = i_sys16 && io_cyc;
   wire lane_hi  = i_sys16 && !i_sbhe_n;
   wire lane_lo  = !i_sys16 || !i_sa_low[0];
   wire prom_p0  = i_prom_is_eeprom ? i_ee_clock : i_id_addr[0];
   wire prom_p1  = i_prom_is_eeprom ? i_ee_sdout : i_id_addr[1];

   // ************************************************************
   // Sequencer and state
   // ************************************************************
   agl_state_t        state_q;
   agl_state_t        state_d;
   logic              rd_prev_q;
   logic              rd_pend_q;
   logic              rd_ok_q;
   logic              wr_done_q;
   logic [ADDR_W-1:0] tx_ptr_q;
   logic [ADDR_W-1:0] rx_ptr_q;
   logic [DATA_W-1:0] rdata_q;

   wire               rd_start = rd_act && !rd_prev_q;
   wire               f_in_rdy;
   wire               f_out_vld;
   wire [FIFO_W-1:0]  f_out;
   wire               f_push   = wr_act && !wr_done_q;
   wire               f_pop    = state_q == ST_WR;
   // Byte mode keeps only the low lane, so width select picks the step
   wire [ADDR_W-1:0]  step     = i_buffer_width_select ? STEP_W16 : STEP_W8;
   wire [1:0]         f_lanes  = i_buffer_width_select ? f_out[FIFO_W-1 -: 2] : 2'b01;

   // Pending writes drain first so a read never overtakes buffered data
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:
         begin
            if (f_out_vld)
               state_d = ST_WR;
            else if (rd_pend_q)
               state_d = ST_RD;
         end
         ST_WR:   state_d = ST_IDLE;
         ST_RD:   state_d = ST_DONE;
         ST_DONE: state_d = ST_IDLE;
      endcase
   end

   agl_fifo
   #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_en    (run),
      .i_valid (f_push),
      .i_data  ({lane_hi, lane_lo, i_sd}),
      .o_ready (f_in_rdy),
      .o_valid (f_out_vld),
      .o_data  (f_out),
      .i_ready (f_pop)
   );

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state_q   <= ST_IDLE;
         rd_prev_q <= 1'b0;
         rd_pend_q <= 1'b0;
         rd_ok_q   <= 1'b0;
         wr_done_q <= 1'b0;
         tx_ptr_q  <= TX_BASE;
         rx_ptr_q  <= RX_BASE;
         rdata_q   <= DATA_RST;
      end
      else if (run)
      begin
         state_q   <= state_d;
         rd_prev_q <= rd_act;
         rd_pend_q <= (rd_start && buf_rd) || (rd_pend_q && state_q != ST_RD);
         rd_ok_q   <= buf_rd && (rd_ok_q || state_q == ST_DONE);
         wr_done_q <= wr_act && (wr_done_q || f_in_rdy);
         if (state_q == ST_WR)
            tx_ptr_q <= tx_ptr_q + step;
         // Sample while the read strobe still stands; the bus floats after
         if (state_q == ST_RD)
            rdata_q <= i_buf_data;
         if (state_q == ST_DONE)
            rx_ptr_q <= rx_ptr_q + step;
      end
   end

   // ************************************************************
   // Registered pins
   // ************************************************************
   wire ready_now = wr_done_q || rd_ok_q || cfg_rd;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_dma_req                    <= 1'b0;
         o_host_channel_ready         <= 1'b0;
         o_io16_n                     <= 1'b1;
         o_upper_lane_xcvr_enable_n   <= 1'b1;
         o_lower_lane_xcvr_enable_n   <= 1'b1;
         o_xcvr_dir                   <= 1'b0;
         o_jumper_cfg1_strobe_n       <= 1'b1;
         o_jumper_cfg2_strobe_n       <= 1'b1;
         o_sd                         <= DATA_RST;
         o_sd_oe                      <= 1'b0;
         o_remote_reset_out           <= 1'b0;
         o_sw_control_out             <= 1'b1;
         o_prom_type_select           <= 1'b0;
         o_prom_clock_or_addr0        <= 1'b0;
         o_prom_sdout_or_addr1        <= 1'b0;
         o_prom_sdin_or_addr2         <= 1'b0;
         o_prom_sdin_or_addr2_oe      <= 1'b0;
         o_ee_sdin                    <= 1'b0;
         o_buf_addr                   <= TX_BASE;
         o_buf_data                   <= DATA_RST;
         o_buf_data_oe                <= 1'b0;
         o_buffer_upper_byte_select_n <= 1'b1;
         o_buffer_lower_byte_select_n <= 1'b1;
         o_buffer_write_strobe_n      <= 1'b1;
         o_buffer_read_strobe_n       <= 1'b1;
      end
      else if (run)
      begin
         o_dma_req                  <= i_rx_avail || f_in_rdy;
         o_host_channel_ready       <= i_ready_polarity_strap ? ready_now : !ready_now;
         o_io16_n                   <= !(wide && (rd_act || wr_act));
         // Jumper register drives the data bus itself, so lanes stay off
         o_upper_lane_xcvr_enable_n <= !(lane_hi && (buf_rd || wr_act));
         o_lower_lane_xcvr_enable_n <= !(lane_lo && (buf_rd || wr_act));
         o_xcvr_dir                 <= wr_act;
         o_jumper_cfg1_strobe_n     <= !(cfg1_rd && rd_start);
         o_jumper_cfg2_strobe_n     <= !(cfg2_rd && rd_start);
         o_sd                       <= rdata_q;
         o_sd_oe                    <= buf_rd && rd_ok_q;
         o_remote_reset_out         <= i_remote_reset_enable && i_special_packet_seen;
         o_sw_control_out           <= !i_sw_control_bit;
         o_prom_type_select         <= i_prom_is_eeprom;
         o_prom_clock_or_addr0      <= prom_p0;
         o_prom_sdout_or_addr1      <= prom_p1;
         o_prom_sdin_or_addr2       <= i_id_addr[2];
         o_prom_sdin_or_addr2_oe    <= !i_prom_is_eeprom;
         o_ee_sdin                  <= i_prom_is_eeprom && i_prom_sdin_or_addr2;
         o_buf_addr                 <= (state_d == ST_WR) ? tx_ptr_q : rx_ptr_q;
         o_buf_data                 <= f_out[DATA_W-1:0];
         o_buf_data_oe              <= state_d == ST_WR;
         o_buffer_upper_byte_select_n <= !((state_d == ST_WR && f_lanes[1])
                                         || (state_d == ST_RD && i_buffer_width_select));
         o_buffer_lower_byte_select_n <= !((state_d == ST_WR && f_lanes[0])
                                         || state_d == ST_RD);
         o_buffer_write_strobe_n    <= state_d != ST_WR;
         o_buffer_read_strobe_n     <= state_d != ST_RD;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   dma_request_a: assert property ((i_rx_avail && run) |=> o_dma_req)
      else $error("DMA request missing with receive data");
   ready_polarity_a: assert property
      ((run && cfg_rd && i_ready_polarity_strap) |=> o_host_channel_ready)
      else $error("Ready not asserted with high polarity");
   ready_low_pol_a: assert property
      ((run && cfg_rd && !i_ready_polarity_strap) |=> !o_host_channel_ready)
      else $error("Ready not asserted with low polarity");
   io16_wide_a: assert property ((run && wide && wr_act) |=> !o_io16_n)
      else $error("Sixteen bit indication missing");
   xcvr_idle_a: assert property
      ((run && !hit) |=> (o_upper_lane_xcvr_enable_n && o_lower_lane_xcvr_enable_n))
      else $error("Transceiver enabled without a cycle");
   xcvr_dir_a: assert property ((run && wr_act) |=> o_xcvr_dir)
      else $error("Direction not set for write");
   cfg_strobe_pulse_a: assert property
      (!o_jumper_cfg1_strobe_n |=> o_jumper_cfg1_strobe_n)
      else $error("Config strobe longer than one cycle");
   cfg2_strobe_a: assert property
      ((run && cfg2_rd && rd_start) |=> !o_jumper_cfg2_strobe_n)
      else $error("Second config strobe missing");
   prom_pin_dir_a: assert property
      (o_prom_type_select |-> !o_prom_sdin_or_addr2_oe)
      else $error("Serial input pin driven in EEPROM mode");
   remote_reset_a: assert property
      ((run && !i_remote_reset_enable) |=> !o_remote_reset_out)
      else $error("Remote reset active while disabled");
   sw_control_a: assert property (run |=> (o_sw_control_out == !$past(i_sw_control_bit)))
      else $error("Control pin not complement of bit");
   buf_write_seq_a: assert property
      (!o_buffer_write_strobe_n |-> (o_buf_data_oe && o_buffer_read_strobe_n))
      else $error("Write strobe without data drive");
   read_seq_a: assert property ((run && state_q == ST_DONE && buf_rd) |=> rd_ok_q)
      else $error("Read data not marked after buffer read");
   powerdown_hold_a: assert property (i_powerdown_bit |=> $stable(state_q))
      else $error("State moved during powerdown");

   write_cov: cover property (!o_buffer_write_strobe_n);
   read_cov: cover property (state_q == ST_DONE);
   cfg_cov: cover property (!o_jumper_cfg1_strobe_n);
   dma_cov: cover property (dma_cyc && wr_act);
endmodule

// *** tb/agl_sram_model.sv ***
`timescale 1ns/1ps

// ************************************************************
// Packet buffer SRAM, asynchronous read
// ************************************************************
module agl_sram_model
   import agl_pkg::*;
(
   // Strobes and address from the block
   input  wire logic              i_clk,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_data,
   input  wire logic              i_hi_sel_n,
   input  wire logic              i_lo_sel_n,
   input  wire logic              i_we_n,
   input  wire logic              i_oe_n,
   // Read data and write record
   output logic [DATA_W-1:0]      o_data,
   output logic [ADDR_W-1:0]      o_last_addr,
   output logic [DATA_W-1:0]      o_last_data
);
   logic [DATA_W-1:0] mem [0:65535];
   logic [DATA_W-1:0] held_q;
   wire               rd_on = !i_oe_n && !(i_hi_sel_n && i_lo_sel_n);

   // Unwritten words hold a known pattern
   initial
   begin
      for (int i = 0; i < 65536; i++)
         mem[i] = 16'(i) ^ 16'ha5c3;
      held_q = 16'h0000;
   end

   // Released bus shows the inverse, never a stale word
   assign o_data = rd_on ? mem[i_addr] : ~held_q;

   always @(posedge i_clk)
   begin
      if (rd_on)
         held_q <= mem[i_addr];
      if (!i_we_n && !i_hi_sel_n)
         mem[i_addr][15:8] <= i_data[15:8];
      if (!i_we_n && !i_lo_sel_n)
         mem[i_addr][7:0] <= i_data[7:0];
      if (!i_we_n)
      begin
         o_last_addr <= i_addr;
         o_last_data <= i_data;
      end
   end
endmodule

// *** tb/agl_glue_bench.sv ***
`timescale 1ns/1ps

module agl_glue_bench;
   import agl_pkg::*;
   // ************************************************************
   // Signals
   // ************************************************************
   logic i_clk, i_rst, i_dev_sel, i_ior_n, i_iow_n, i_aen, i_dmack_n, i_sbhe_n;
   logic i_sys16, i_ready_polarity_strap, i_rx_avail, i_buffer_width_select;
   logic i_powerdown_bit, i_remote_reset_enable, i_special_packet_seen;
   logic i_sw_control_bit, i_prom_is_eeprom, i_ee_clock, i_ee_sdout, ee_bit;
   logic [4:0] i_sa_low;
   logic [2:0] i_id_addr;
   logic [DATA_W-1:0] i_sd, o_sd, i_buf_data, o_buf_data, last_data, c_sd;
   logic [ADDR_W-1:0] o_buf_addr, last_addr, tx_ptr;
   logic o_sd_oe, o_dma_req, o_host_channel_ready, o_io16_n, o_xcvr_dir;
   logic o_upper_lane_xcvr_enable_n, o_lower_lane_xcvr_enable_n;
   logic o_jumper_cfg1_strobe_n, o_jumper_cfg2_strobe_n, o_remote_reset_out;
   logic o_sw_control_out, o_prom_type_select, o_prom_clock_or_addr0;
   logic o_prom_sdout_or_addr1, o_prom_sdin_or_addr2, o_prom_sdin_or_addr2_oe;
   logic o_ee_sdin, o_buf_data_oe, o_buffer_upper_byte_select_n;
   logic o_buffer_lower_byte_select_n, o_buffer_write_strobe_n;
   logic o_buffer_read_strobe_n, c_dir, c_io16, c_oe;
   logic [1:0] c_en;
   int bad_count, checked, n_c1, n_c2, n_we, n_oe, n_en;
   // Shared pin: the EEPROM drives it only while the block does not
   wire i_prom_sdin_or_addr2 = o_prom_sdin_or_addr2_oe ? o_prom_sdin_or_addr2 : ee_bit;

   agl_glue u_dut (.*);
   agl_sram_model u_mem (.i_clk(i_clk), .i_addr(o_buf_addr), .i_data(o_buf_data),
      .i_hi_sel_n(o_buffer_upper_byte_select_n), .i_lo_sel_n(o_buffer_lower_byte_select_n),
      .i_we_n(o_buffer_write_strobe_n), .i_oe_n(o_buffer_read_strobe_n),
      .o_data(i_buf_data), .o_last_addr(last_addr), .o_last_data(last_data));

   initial
   begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   // Strobe and lane enable low-cycle counters, judged as deltas
   always @(posedge i_clk)
   begin
      n_c1 += (o_jumper_cfg1_strobe_n === 1'b0);
      n_c2 += (o_jumper_cfg2_strobe_n === 1'b0);
      n_we += (o_buffer_write_strobe_n === 1'b0);
      n_oe += (o_buffer_read_strobe_n === 1'b0);
      n_en += (o_upper_lane_xcvr_enable_n === 1'b0 || o_lower_lane_xcvr_enable_n === 1'b0);
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #5;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Host cycle held until ready is seen asserted
   task automatic host(input logic wr, input logic dma, input logic [4:0] a,
                       input logic [15:0] d);
      int n;
      n = 0;
      {i_aen, i_dmack_n, i_dev_sel, i_sa_low, i_sd} = {dma, !dma, !dma, a, d};
      {i_iow_n, i_ior_n} = {!wr, wr};
      step(1);
      while (o_host_channel_ready !== i_ready_polarity_strap && n < 40)
      begin
         step(1);
         n++;
      end
      chk(n < 40, 1);
      {c_oe, c_sd} = {o_sd_oe, o_sd};
      {c_dir, c_io16, c_en} = {o_xcvr_dir, o_io16_n, o_upper_lane_xcvr_enable_n,
                               o_lower_lane_xcvr_enable_n};
      {i_iow_n, i_ior_n, i_sd} = {2'b11, ~d};
      step(1);
      {i_aen, i_dmack_n, i_dev_sel} = 3'b010;
      step(4);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_pins;
      for (int i = 0; i < 8; i++)
      begin
         {i_remote_reset_enable, i_special_packet_seen, i_sw_control_bit} = 3'(i);
         {i_prom_is_eeprom, i_ee_clock, i_ee_sdout, ee_bit} = {3'(i), !i[1]};
         i_id_addr = 3'(i ^ 5);
         step(2);
         chk(o_remote_reset_out, i[2] & i[1]);
         chk(o_sw_control_out, !i[0]);
         chk(o_prom_type_select, i[2]);
         if (i[2])
            chk({o_prom_clock_or_addr0, o_prom_sdout_or_addr1, o_prom_sdin_or_addr2_oe,
                 o_ee_sdin}, {i[1], i[0], 1'b0, !i[1]});
         else
            chk({o_prom_clock_or_addr0, o_prom_sdout_or_addr1, i_prom_sdin_or_addr2,
                 o_prom_sdin_or_addr2_oe},
                {i_id_addr[0], i_id_addr[1], i_id_addr[2], 1'b1});
      end
      $display("test pins done");
   endtask

   task automatic t_write;
      int w;
      for (int s = 0; s < 2; s++)
      begin
         i_ready_polarity_strap = s[0];
         w = n_we;
         host(1'b1, 1'b0, 5'h00, 16'h1234 + 16'(s));
         chk({c_dir, c_io16, c_en}, 4'b1000);
         chk({last_addr, last_data}, {tx_ptr, 16'h1234 + 16'(s)});
         chk(n_we - w, 1);
         tx_ptr += STEP_W16;
      end
      $display("test write done");
   endtask

   task automatic t_read_cfg;
      int a, b, e;
      a = n_oe;
      host(1'b0, 1'b0, 5'h00, DATA_RST);
      chk({c_oe, c_sd}, {1'b1, RX_BASE ^ 16'ha5c3});
      chk({c_dir, c_io16, c_en}, 4'b0000);
      chk(n_oe - a, 1);
      for (int k = 0; k < 2; k++)
      begin
         {a, b, e} = {n_c1, n_c2, n_en};
         host(1'b0, 1'b0, JUMPER_CFG1_ADDR + 5'(k), DATA_RST);
         chk(n_c1 - a, k == 0);
         chk(n_c2 - b, k == 1);
         chk(n_en - e, 0);
      end
      $display("test read done");
   endtask

   task automatic t_dma_width;
      i_rx_avail = 1'b1;
      step(2);
      chk(o_dma_req, 1);
      i_rx_avail = 1'b0;
      host(1'b1, 1'b1, 5'h00, 16'hbeef);
      chk({last_addr, last_data}, {tx_ptr, 16'hbeef});
      chk(o_dma_req, 1);
      tx_ptr += STEP_W16;
      {i_buffer_width_select, i_sys16, i_sbhe_n} = 3'b001;
      host(1'b1, 1'b0, 5'h00, 16'h3c5a);
      chk({c_io16, c_en}, 3'b110);
      chk({last_addr, last_data[7:0]}, {tx_ptr, 8'h5a});
      tx_ptr += STEP_W8;
      {i_buffer_width_select, i_sys16, i_sbhe_n} = 3'b110;
      $display("test dma and width done");
   endtask

   task automatic t_pwr;
      i_sw_control_bit = 1'b0;
      step(2);
      {i_powerdown_bit, i_sw_control_bit} = 2'b11;
      step(3);
      chk(o_sw_control_out, 1);
      i_powerdown_bit = 1'b0;
      step(2);
      chk(o_sw_control_out, 0);
      $display("test powerdown done");
   endtask

   // Write burst through the buffer path, each word landing in order
   task automatic t_burst;
      int w;
      w = n_we;
      for (int k = 0; k < FIFO_DEPTH; k++)
      begin
         host(1'b1, 1'b0, 5'h00, 16'h0100 + 16'(k));
         chk({last_addr, last_data}, {tx_ptr, 16'h0100 + 16'(k)});
         chk(o_dma_req, 1);
         tx_ptr += STEP_W16;
      end
      chk(n_we - w, FIFO_DEPTH);
      $display("test burst done");
   endtask

   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   initial
   begin
      {i_rst, i_dev_sel, i_ior_n, i_iow_n, i_aen, i_dmack_n} = 6'b100111;
      {i_sbhe_n, i_sys16, i_ready_polarity_strap, i_rx_avail} = 4'b0110;
      {i_buffer_width_select, i_powerdown_bit, i_remote_reset_enable} = 3'b100;
      {i_special_packet_seen, i_sw_control_bit, i_prom_is_eeprom} = 3'b000;
      {i_ee_clock, i_ee_sdout, ee_bit} = 3'b000;
      {i_sa_low, i_id_addr, i_sd} = '0;
      tx_ptr = TX_BASE;
      step(8);
      chk({o_dma_req, o_io16_n, o_sw_control_out, o_buffer_write_strobe_n,
           o_jumper_cfg1_strobe_n, o_jumper_cfg2_strobe_n, o_buf_addr}, {6'h1f, 16'h0000});
      i_rst = 1'b0;
      step(1);
      t_pins();
      t_write();
      t_read_cfg();
      t_dma_width();
      t_pwr();
      t_burst();
      tally_and_finish();
   end

   initial
   begin
      repeat (4000) @(posedge i_clk);
      bad_count++;
      tally_and_finish();
   end
endmodule
